// ===== sldrv_consts.vh
// Notes on behaviour
// - port-2 bit n routes pin n to display
// - port-3 bit n routes pin n; resets zero
// - divider code selects 100/200/400/800 kilohm
// - first sixteenth of slot forces 100 kilohm
// - quarter duty swap bit picks common group
// - bias bit: quarter when clear, third when set
// - one RAM byte per segment, bit k=common k
// - enable starts scan; mode picks LCD or LED
// - duty code picks eight/six/five/four commons
// - contrast sets level (17+code)/32 of supply
// - scan ticks from 32 kHz source, ~64 Hz
`ifndef SLDRV_CONSTS_VH
`define SLDRV_CONSTS_VH
// register indices; byte address is four times the index
`define SLD_IDX_OTCTL 16'h008f
`define SLD_IDX_P3EN 16'h00b3
`define SLD_IDX_P2EN 16'h00a3
`define SLD_IDX_MAIN 16'h0093
`define SLD_IDX_STAT 16'h00c0
`define SLD_IDX_CLKS 16'h00c1
`define SLD_IDX_RAM0 16'h2000
`define SLD_IDX_RAML 16'h201b
`define SLD_NSEG 28
// reset values
`define SLD_RST_BYTE 8'h00
// main control fields
`define SLD_MAIN_ON 7
`define SLD_MAIN_MODE 6
`define SLD_MAIN_DUTY_HI 5
`define SLD_MAIN_DUTY_LO 4
`define SLD_MAIN_VL_HI 3
`define SLD_MAIN_VL_LO 0
// output/bias/divider control fields
`define SLD_OT_RES_HI 3
`define SLD_OT_RES_LO 2
`define SLD_OT_SWAP 1
`define SLD_OT_BIAS 0
// duty codes
`define SLD_DUTY_8 2'b00
`define SLD_DUTY_6 2'b01
`define SLD_DUTY_5 2'b10
`define SLD_DUTY_4 2'b11
// divider code forced during the boost part of a slot
`define SLD_RES_100K 2'b00
// contrast offset and scale
`define SLD_VL_BASE 6'd17
`define SLD_VL_DEN 32
// timing: 32768 Hz source, 64 Hz frame
`define SLD_SRC_HZ 32768
`define SLD_FRAME_HZ 64
`define SLD_FRAME_TICKS (`SLD_SRC_HZ / `SLD_FRAME_HZ)
`define SLD_BOOST_DIV 16
// axi responses
`define SLD_RESP_OK 2'b00
`define SLD_RESP_ERR 2'b10
`endif

// ===== sldrv_scan.v
`include "sldrv_consts.vh"
module sldrv_scan (
  // clock and reset
  input wire clk,
  input wire rst,
  // control
  input wire tick,
  input wire run,
  input wire [1:0] duty,
  input wire swap,
  // state
  output wire [2:0] com_idx,
  output wire boost,
  output wire frame_phase
);
  reg [7:0] cnt_q;
  reg [2:0] com_q;
  reg phase_q;
  reg [2:0] first;
  reg [2:0] last;
  reg [7:0] slot;
  localparam [31:0] SLOT8 = `SLD_FRAME_TICKS / 8;
  localparam [31:0] SLOT6 = `SLD_FRAME_TICKS / 6;
  localparam [31:0] SLOT5 = `SLD_FRAME_TICKS / 5;
  localparam [31:0] SLOT4 = `SLD_FRAME_TICKS / 4;
  wire [31:0] boost_len = slot / `SLD_BOOST_DIV;
  wire out_rng = (com_q < first) || (com_q > last);

  always @* begin
    last = 3'd7;
    case (duty)
      `SLD_DUTY_8: begin
        first = 3'd0;
        slot = SLOT8[7:0];
      end
      `SLD_DUTY_6: begin
        first = 3'd2;
        slot = SLOT6[7:0];
      end
      `SLD_DUTY_5: begin
        first = 3'd3;
        slot = SLOT5[7:0];
      end
      default: begin
        first = swap ? 3'd0 : 3'd4;
        last = swap ? 3'd3 : 3'd7;
        slot = SLOT4[7:0];
      end
    endcase
  end

  // a duty change that leaves the common outside the new range restarts at the first common, never a stale one
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 8'h00;
      com_q <= 3'h0;
      phase_q <= 1'b0;
    end else if (!run) begin
      cnt_q <= 8'h00;
      com_q <= first;
      phase_q <= 1'b0;
    end else if (com_q < first || com_q > last) begin
      cnt_q <= 8'h00;
      com_q <= first;
    end else if (tick) begin
      if (cnt_q == slot - 8'h01) begin
        cnt_q <= 8'h00;
        if (com_q == last) begin
          com_q <= first;
          phase_q <= ~phase_q;
        end else begin
          com_q <= com_q + 3'h1;
        end
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end

  // the common register lags a duty or swap change by one cycle; never show a stale line
  assign com_idx = out_rng ? first : com_q;
  assign boost = run && (cnt_q < boost_len[7:0]);
  assign frame_phase = phase_q;
endmodule // sldrv_scan

// ===== sldrv_top.v
`include "sldrv_consts.vh"
module sldrv_top #(
  parameter AW = 16
) (
  // clock and reset
  input wire MCLK,
  input wire RST,
  // axi4-lite write address
  input wire [AW-1:0] AWADDR,
  input wire AWVALID,
  output wire AWREADY,
  // axi4-lite write data
  input wire [31:0] WDATA,
  input wire [3:0] WSTRB,
  input wire WVALID,
  output wire WREADY,
  // axi4-lite write response
  output wire [1:0] BRESP,
  output wire BVALID,
  input wire BREADY,
  // axi4-lite read address
  input wire [AW-1:0] ARADDR,
  input wire ARVALID,
  output wire ARREADY,
  // axi4-lite read data
  output wire [31:0] RDATA,
  output wire [1:0] RRESP,
  output wire RVALID,
  input wire RREADY,
  // scan clock sources
  input wire LRC_CLK,
  input wire XTAL_CLK,
  // display drive
  output wire [7:0] COM_ACTIVE,
  output wire [27:0] SEG_ON,
  output wire [27:0] SEG_VALID,
  output wire FRAME_PHASE,
  output wire SCAN_ACTIVE,
  output wire LED_MODE,
  output wire BIAS_THIRD,
  output wire [1:0] DIV_RES_SEL,
  output wire [5:0] LCD_LEVEL_NUM,
  // pin routing
  output wire [7:0] PORT2_PIN_DISPLAY_DRIVE,
  output wire [7:0] PORT3_PIN_DISPLAY_DRIVE
);
  localparam [3:0] R_NONE = 4'h0;
  localparam [3:0] R_MAIN = 4'h1;
  localparam [3:0] R_OT = 4'h2;
  localparam [3:0] R_P2 = 4'h3;
  localparam [3:0] R_P3 = 4'h4;
  localparam [3:0] R_STAT = 4'h5;
  localparam [3:0] R_CLKS = 4'h6;
  localparam [3:0] R_RAM = 4'h7;

  // byte address to register code; low two bits ignored
  function [3:0] dec;
    input [AW-1:0] a;
    reg [AW-3:0] ix;
    begin
      ix = a[AW-1:2];
      if (ix == `SLD_IDX_MAIN) dec = R_MAIN;
      else if (ix == `SLD_IDX_OTCTL) dec = R_OT;
      else if (ix == `SLD_IDX_P2EN) dec = R_P2;
      else if (ix == `SLD_IDX_P3EN) dec = R_P3;
      else if (ix == `SLD_IDX_STAT) dec = R_STAT;
      else if (ix == `SLD_IDX_CLKS) dec = R_CLKS;
      else if (ix >= `SLD_IDX_RAM0 && ix <= `SLD_IDX_RAML) dec = R_RAM;
      else dec = R_NONE;
    end
  endfunction

  // segment slot within display RAM
  function [4:0] ram_ix;
    input [AW-1:0] a;
    begin
      ram_ix = a[6:2];
    end
  endfunction

  // registers
  reg [7:0] main_q;
  reg [7:0] ot_q;
  reg [7:0] p2_q;
  reg [7:0] p3_q;
  reg clks_q;
  reg [7:0] dram [0:`SLD_NSEG-1];

  // write channel state
  reg [AW-1:0] awa_q;
  reg aw_q;
  reg [31:0] wd_q;
  reg [3:0] ws_q;
  reg w_q;
  reg bv_q;
  reg [1:0] br_q;
  // read channel state
  reg rv_q;
  reg [31:0] rd_q;
  reg [1:0] rr_q;
  reg [31:0] rd_d;
  reg [1:0] rr_d;

  wire do_wr = aw_q && w_q && !bv_q;
  wire [3:0] wsel = dec(awa_q);
  wire wlane = ws_q[0];
  wire [7:0] wb = wd_q[7:0];
  integer i;

  assign AWREADY = !aw_q && !bv_q;
  assign WREADY = !w_q && !bv_q;
  assign BVALID = bv_q;
  assign BRESP = br_q;
  assign ARREADY = !rv_q;
  assign RVALID = rv_q;
  assign RDATA = rd_q;
  assign RRESP = rr_q;

  // address and data are latched in either order; answer follows both
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= {AW{1'b0}};
      wd_q <= 32'h00000000;
      ws_q <= 4'h0;
      bv_q <= 1'b0;
      br_q <= `SLD_RESP_OK;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_q <= 1'b1;
        awa_q <= AWADDR;
      end
      if (WVALID && WREADY) begin
        w_q <= 1'b1;
        wd_q <= WDATA;
        ws_q <= WSTRB;
      end
      if (do_wr) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        bv_q <= 1'b1;
        br_q <= (wsel == R_NONE) ? `SLD_RESP_ERR : `SLD_RESP_OK;
      end else if (bv_q && BREADY) begin
        bv_q <= 1'b0;
      end
    end
  end

  // register stores; status is read-only, writes to it are dropped
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      main_q <= `SLD_RST_BYTE;
      ot_q <= `SLD_RST_BYTE;
      p2_q <= `SLD_RST_BYTE;
      p3_q <= `SLD_RST_BYTE;
      clks_q <= 1'b0;
    end else if (do_wr && wlane) begin
      case (wsel)
        R_MAIN: main_q <= wb;
        R_OT: ot_q <= wb;
        R_P2: p2_q <= wb;
        R_P3: p3_q <= wb;
        R_CLKS: clks_q <= wb[0];
        default: clks_q <= clks_q;
      endcase
    end
  end

  // display RAM is not reset, as on the original memory
  always @(posedge MCLK) begin
    if (do_wr && wlane && wsel == R_RAM) begin
      dram[ram_ix(awa_q)] <= wb;
    end
  end

  // scan clock: selected source passes three flops; edge counts on agreement
  reg sy1_q;
  reg sy2_q;
  reg sy3_q;
  reg lvl_q;
  wire src_pin = clks_q ? XTAL_CLK : LRC_CLK;
  wire lvl_d = (sy2_q == sy3_q) ? sy3_q : lvl_q;
  wire tick = lvl_d && !lvl_q;
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      sy1_q <= 1'b0;
      sy2_q <= 1'b0;
      sy3_q <= 1'b0;
      lvl_q <= 1'b0;
    end else begin
      sy1_q <= src_pin;
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
      lvl_q <= lvl_d;
    end
  end

  wire run = main_q[`SLD_MAIN_ON];
  wire [1:0] duty = main_q[`SLD_MAIN_DUTY_HI:`SLD_MAIN_DUTY_LO];
  wire swap = ot_q[`SLD_OT_SWAP];
  wire [2:0] com_idx;
  wire boost;
  wire phase;

  sldrv_scan u_scan (
    .clk(MCLK),
    .rst(RST),
    .tick(tick),
    .run(run),
    .duty(duty),
    .swap(swap),
    .com_idx(com_idx),
    .boost(boost),
    .frame_phase(phase)
  );

  // read mux
  always @* begin
    rd_d = 32'h00000000;
    rr_d = `SLD_RESP_OK;
    case (dec(ARADDR))
      R_MAIN: rd_d[7:0] = main_q;
      R_OT: rd_d[7:0] = ot_q;
      R_P2: rd_d[7:0] = p2_q;
      R_P3: rd_d[7:0] = p3_q;
      R_CLKS: rd_d[0] = clks_q;
      R_STAT: rd_d[5:0] = {run, phase, boost, com_idx};
      R_RAM: rd_d[7:0] = dram[ram_ix(ARADDR)];
      default: rr_d = `SLD_RESP_ERR;
    endcase
  end

  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      rv_q <= 1'b0;
      rd_q <= 32'h00000000;
      rr_q <= `SLD_RESP_OK;
    end else if (ARVALID && ARREADY) begin
      rv_q <= 1'b1;
      rd_q <= rd_d;
      rr_q <= rr_d;
    end else if (rv_q && RREADY) begin
      rv_q <= 1'b0;
    end
  end

  // lowest segment pin left free by the chosen common group
  reg [4:0] seg_lo;
  always @* begin
    case (duty)
      `SLD_DUTY_8: seg_lo = 5'd4;
      `SLD_DUTY_6: seg_lo = 5'd2;
      `SLD_DUTY_5: seg_lo = 5'd1;
      default: seg_lo = swap ? 5'd4 : 5'd0;
    endcase
  end

  // drive state; registered so pins never glitch on RAM writes
  reg [7:0] com_q;
  reg [27:0] seg_q;
  reg [27:0] sval_q;
  reg [7:0] com_d;
  reg [27:0] seg_d;
  reg [27:0] sval_d;
  reg [1:0] res_q;
  reg [5:0] vl_q;

  always @* begin
    com_d = 8'h00;
    seg_d = 28'h0000000;
    sval_d = 28'h0000000;
    if (run) begin
      com_d[com_idx] = 1'b1;
      for (i = 0; i < `SLD_NSEG; i = i + 1) begin
        if (i >= seg_lo) begin
          sval_d[i] = 1'b1;
          seg_d[i] = dram[i][com_idx];
        end
      end
    end
  end

  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      com_q <= 8'h00;
      seg_q <= 28'h0000000;
      sval_q <= 28'h0000000;
      res_q <= `SLD_RES_100K;
      vl_q <= 6'h00;
    end else begin
      com_q <= com_d;
      seg_q <= seg_d;
      sval_q <= sval_d;
      // short low-resistance burst speeds the common edge; costs supply current
      res_q <= boost ? `SLD_RES_100K : ot_q[`SLD_OT_RES_HI:`SLD_OT_RES_LO];
      vl_q <= `SLD_VL_BASE + {2'b00, main_q[`SLD_MAIN_VL_HI:`SLD_MAIN_VL_LO]};
    end
  end

  assign COM_ACTIVE = com_q;
  assign SEG_ON = seg_q;
  assign SEG_VALID = sval_q;
  assign FRAME_PHASE = phase;
  assign SCAN_ACTIVE = run;
  assign LED_MODE = main_q[`SLD_MAIN_MODE];
  assign BIAS_THIRD = ot_q[`SLD_OT_BIAS];
  assign DIV_RES_SEL = res_q;
  assign LCD_LEVEL_NUM = vl_q;
  assign PORT2_PIN_DISPLAY_DRIVE = p2_q;
  assign PORT3_PIN_DISPLAY_DRIVE = p3_q;
endmodule // sldrv_top

// ===== sldrv_panel.sv
module sldrv_panel (
  // panel clock and clear
  input wire logic clk,
  input wire logic clr,
  // common and segment drive
  input wire logic [7:0] com,
  input wire logic [27:0] seg,
  // what the glass has shown since clear
  output logic [7:0] seen,
  output logic [27:0] lit
);
  timeunit 1ns;
  timeprecision 1ns;
  // passive glass: it only integrates what it is driven with, nothing drives back
  always @(posedge clk) begin
    if (clr) begin
      seen <= 8'h00;
      lit <= 28'h0;
    end else begin
      seen <= seen | com;
      if (com != 8'h00) lit <= lit | seg;
    end
  end
endmodule // sldrv_panel

// ===== sldrv_top_assertions.sv
module sldrv_chk (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // register bus
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic [1:0] BRESP,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic RVALID,
  input wire logic RREADY,
  // display drive
  input wire logic [7:0] COM_ACTIVE,
  input wire logic [27:0] SEG_ON,
  input wire logic [27:0] SEG_VALID,
  input wire logic SCAN_ACTIVE,
  input wire logic [1:0] DIV_RES_SEL
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  sequence wr_taken;
    AWVALID && AWREADY && WVALID && WREADY;
  endsequence
  sequence b_answer;
    !AWREADY && !WREADY ##1 BVALID;
  endsequence
  write_answer_a: assert property (wr_taken |=> b_answer) else $error("write answer late");
  b_hold_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped");
  read_answer_a: assert property (ARVALID && ARREADY |=> RVALID && !ARREADY)
    else $error("read answer late");
  r_hold_a: assert property (RVALID && !RREADY |=> RVALID) else $error("read data dropped");
  com_onehot_a: assert property ($onehot0(COM_ACTIVE)) else $error("two commons active");
  seg_gate_a: assert property ((SEG_ON & ~SEG_VALID) == 28'h0)
    else $error("non-segment pin driven");
  scan_off_a: assert property (!SCAN_ACTIVE [*3] |-> COM_ACTIVE == 8'h00)
    else $error("common active while off");
  scan_on_a: assert property ($rose(SCAN_ACTIVE) |-> ##[1:300] COM_ACTIVE != 8'h00)
    else $error("scan did not start");
  boost_switch_a: assert property ($changed(COM_ACTIVE) && COM_ACTIVE != 8'h00
    |-> ##[0:1] DIV_RES_SEL == 2'b00) else $error("no low divider at common switch");
endmodule // sldrv_chk

bind sldrv_top sldrv_chk u_chk (.MCLK(MCLK), .RST(RST), .AWVALID(AWVALID), .AWREADY(AWREADY),
  .WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP),
  .ARVALID(ARVALID), .ARREADY(ARREADY), .RVALID(RVALID), .RREADY(RREADY),
  .COM_ACTIVE(COM_ACTIVE), .SEG_ON(SEG_ON), .SEG_VALID(SEG_VALID),
  .SCAN_ACTIVE(SCAN_ACTIVE), .DIV_RES_SEL(DIV_RES_SEL));

// ===== sldrv_top_tb.sv
module sldrv_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0, rst = 1'b1, lrc = 1'b0, xtal = 1'b0, clr = 1'b0, mon = 1'b0, hi = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [15:0] awaddr = 16'h0, araddr = 16'h0;
  logic [31:0] wdata = 32'h0, seed = 32'd70, rdata;
  logic awready, wready, bvalid, arready, rvalid, scan_on, led, bias3, phase;
  logic [1:0] bresp, rresp, res_sel;
  logic [7:0] com, p2, p3, seen, com_q = 8'h0;
  logic [7:0] ram [28];
  logic [27:0] seg_on, seg_ok, lit;
  logic [5:0] level;
  logic [3:0] wstrb = 4'hf;
  int errors = 0, comparisons = 0, seg_lo = 0;
  always #50 mclk = ~mclk;
  // scan sources far faster than 32 kHz so a frame fits in a few thousand cycles
  always #410 lrc = ~lrc;
  always #530 xtal = ~xtal;
  sldrv_top DUT (.MCLK(mclk), .RST(rst), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
    .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .LRC_CLK(lrc),
    .XTAL_CLK(xtal), .COM_ACTIVE(com), .SEG_ON(seg_on), .SEG_VALID(seg_ok),
    .FRAME_PHASE(phase), .SCAN_ACTIVE(scan_on), .LED_MODE(led), .BIAS_THIRD(bias3),
    .DIV_RES_SEL(res_sel), .LCD_LEVEL_NUM(level), .PORT2_PIN_DISPLAY_DRIVE(p2),
    .PORT3_PIN_DISPLAY_DRIVE(p3));
  sldrv_panel PANEL (.clk(mclk), .clr(clr), .com(com), .seg(seg_on), .seen(seen), .lit(lit));
  task automatic summarize;
    if (errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (e !== s) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  function logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    rnd = seed[7:0];
  endfunction
  function automatic logic [27:0] expseg(input logic [7:0] c);
    expseg = 28'h0;
    for (int n = 0; n < 28; n++) if (n >= seg_lo) expseg[n] = |(ram[n] & c);
  endfunction
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      // late bready so the response is seen waiting
      if (n == 3) bready <= 1'b1;
    end while (!(bvalid && bready) && n < 50);
    bready <= 1'b0;
    if (n >= 50) begin chk("bus wait", 1, 0); summarize(); end
    chk("bresp", er, bresp);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (arready) arvalid <= 1'b0;
      if (n == 3) rready <= 1'b1;
    end while (!(rvalid && rready) && n < 50);
    rready <= 1'b0;
    if (n >= 50) begin chk("bus wait", 1, 0); summarize(); end
    chk("rdata", {24'h0, ed}, rdata);
    chk("rresp", er, rresp);
  endtask
  always @(posedge mclk) begin
    com_q <= com;
    if (mon && res_sel == 2'b11) hi <= 1'b1;
    if (mon && com != 8'h0 && com == com_q) chk("seg_on", expseg(com), seg_on);
  end
  task automatic scan(input logic [1:0] dt, input logic sw, input logic src, input logic [7:0] ec);
    logic [27:0] vmask;
    seg_lo = (dt == 2'b11) ? (sw ? 4 : 0) : (dt == 2'b00 ? 4 : 3 - dt);
    wr(16'h023c, {4'h0, 2'b11, sw, 1'b0}, 2'b00);
    wr(16'h0304, {7'h0, src}, 2'b00);
    wr(16'h024c, {2'b10, dt, 4'h0}, 2'b00);
    clr <= 1'b1;
    mon <= 1'b1;
    hi <= 1'b0;
    @(posedge mclk);
    clr <= 1'b0;
    repeat (6000) @(posedge mclk);
    mon <= 1'b0;
    chk("commons", ec, seen);
    chk("segments", expseg(ec), lit);
    vmask = 28'hfffffff << seg_lo;
    chk("seg_valid", vmask, seg_ok);
    chk("phase", 1, phase);
    chk("div_res", 1, hi);
    wr(16'h024c, 8'h00, 2'b00);
  endtask
  initial begin
    logic [7:0] d, e, p2e;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    chk("p2 reset", 8'h00, p2);
    chk("p3 reset", 8'h00, p3);
    rd(16'h028c, 8'h00, 2'b00);
    rd(16'h02cc, 8'h00, 2'b00);
    rd(16'h023c, 8'h00, 2'b00);
    rd(16'h0300, 8'h00, 2'b00);
    for (int i = 0; i < 4; i++) begin
      d = rnd();
      p2e = d;
      e = ~d;
      wr(16'h028c, d, 2'b00);
      wr(16'h02cc, e, 2'b00);
      chk("p2 drive", d, p2);
      chk("p3 drive", e, p3);
      rd(16'h02cc, e, 2'b00);
      d[3:2] = i[1:0];
      wr(16'h023c, d, 2'b00);
      @(posedge mclk);
      chk("div_res", i, res_sel);
      chk("bias", d[0], bias3);
      rd(16'h023c, d, 2'b00);
      e = rnd() & 8'h7f;
      wr(16'h024c, e, 2'b00);
      @(posedge mclk);
      chk("level", 6'd17 + e[3:0], level);
      chk("led mode", e[6], led);
    end
    wr(16'h0400, 8'h5a, 2'b10);
    rd(16'h0400, 8'h00, 2'b10);
    // a write with its low byte lane off must leave the register alone
    wstrb <= 4'h0;
    wr(16'h028c, ~p2e, 2'b00);
    wstrb <= 4'hf;
    rd(16'h028c, p2e, 2'b00);
    foreach (ram[n]) begin
      ram[n] = rnd();
      wr(16'h8000 + 16'(4 * n), ram[n], 2'b00);
    end
    foreach (ram[n]) rd(16'h8000 + 16'(4 * n), ram[n], 2'b00);
    scan(2'b00, 1'b0, 1'b0, 8'hff);
    scan(2'b01, 1'b0, 1'b0, 8'hfc);
    scan(2'b10, 1'b0, 1'b1, 8'hf8);
    scan(2'b11, 1'b0, 1'b0, 8'hf0);
    scan(2'b11, 1'b1, 1'b1, 8'h0f);
    summarize();
  end
endmodule // sldrv_top_tb
